// file: logic/clock_prescaler.sv
`timescale 1ns/1ns
// Purpose: one stage of the master clock divider chain, as a tick divider
// Assumes: tick_in is a one-cycle pulse at the stage's input rate
// Notes: ratio of 1 passes the input ticks through one flop
module clock_prescaler
  import codec_ctl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // ticks
  input wire logic tick_in,
  input wire logic [2:0] ratio,
  output logic tick_out
);

  logic [2:0] count;

  // =========================================================================
  // divider
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      count <= 3'h0;
      tick_out <= 1'b0;
    end
    else if (tick_in)
    begin
      // a ratio change takes effect at once, mid-period, since the compare uses the current ratio
      if (count + 3'h1 >= ratio)
      begin
        count <= 3'h0;
        tick_out <= 1'b1;
      end
      else
      begin
        count <= count + 3'h1;
        tick_out <= 1'b0;
      end
    end
    else
    begin
      tick_out <= 1'b0;
    end
  end

endmodule

// file: logic/codec_control.sv
`timescale 1ns/1ns
// Purpose: control registers, master clock divider chain and channel controls
// Assumes: control words arrive already deserialised on ref_clk
// Notes: derived clocks are one-cycle tick enables, not gated clocks
// Operation
// [RULE1] ADC gain 0 to 12 dB, 3 dB steps
// [RULE2] software can mute the ADC
// [RULE3] ADC modulator at 64 times sample rate
// [RULE4] linear phase decimator, 910 us delay at 48k
// [RULE5] peak capture only while peak enable set
// [RULE6] peak held as 6-bit 1 dB code
// [RULE7] peak register read returns highest level
// [RULE8] reading the peak clears it
// [RULE9] DAC mute and volume act independently
// [RULE10] DAC attenuation is a 10-bit value
// [RULE11] low group delay bypasses most filtering
// [RULE12] low group delay gives rate of clock/128
// [RULE13] software can disable the internal reference
// [RULE14] one sample per 256 internal clocks
// [RULE15] internal clock from three chained dividers
// [RULE16] dividers one and two: 1, 2, 3
// [RULE17] divider three: 1, 2, 4
// [RULE18] host writes the divider register
// [RULE19] reset default 48k from 12.288 MHz
// [RULE20] default modulators at clock/4 and clock/2
// [RULE21] 8k to 48k set by clock and dividers
// [RULE22] reset restores defaults, 3072 busy cycles
// [RULE23] 10-bit registers, 16-bit control words
// [RULE24] dividers pass through after reset
// [RULE25] muted ADC gives zero samples, same timing
module codec_control
  import codec_ctl_pkg::*;
#(
  parameter int SAMPLE_W = 24
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control words from the serial port
  input wire logic ctl_valid,
  input wire logic [15:0] ctl_word,
  output logic read_valid,
  output logic [15:0] read_word,
  output logic busy,
  // ADC data path
  input wire logic adc_valid,
  input wire logic [SAMPLE_W-1:0] adc_sample,
  input wire logic [5:0] adc_level_code,
  output logic adc_out_valid,
  output logic [SAMPLE_W-1:0] adc_out,
  // clock ticks
  output logic int_master_tick,
  output logic sample_tick,
  output logic adc_mod_tick,
  output logic dac_mod_tick,
  // channel controls
  output logic [4:0] adc_gain_db,
  output logic adc_mute,
  output logic dac_mute,
  output logic [9:0] dac_attenuation,
  output logic filter_bypass,
  output logic [5:0] decim_delay_samples,
  output logic ref_disable
);

  typedef enum logic [1:0]
  {
    ST_BUSY = 2'b00,
    ST_READY = 2'b01
  } ctl_state_t;

  ctl_state_t state;
  logic [11:0] busy_count;
  logic [9:0] ref_ctrl;
  logic [9:0] clock_div;
  logic [9:0] filter_ctrl;
  logic [9:0] dac_ctrl;
  logic [9:0] adc_ctrl;
  logic [9:0] atten_reg;
  logic word_write;
  logic [3:0] word_addr;
  logic [9:0] word_data;
  logic take;
  logic [9:0] read_data;
  logic [2:0] ratio [3];
  logic [3:0] stage_tick;
  logic [7:0] int_master_clock_count;
  logic next_sample;
  logic low_delay;
  logic [2:0] gain_step;
  peak_if peak_link ();

  assign word_write = ctl_word[WORD_RW_BIT];
  assign word_addr = ctl_word[WORD_ADDR_LSB +: ADDR_W];
  assign word_data = ctl_word[WORD_DATA_LSB +: DATA_W];
  assign take = ctl_valid && (state == ST_READY);
  assign low_delay = filter_ctrl[LOW_DELAY_BIT];

  // =========================================================================
  // reset processing
  // words arriving while busy are dropped, the host must wait for busy low
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= ST_BUSY;
      busy_count <= 12'(RESET_CYCLES - 1);
      busy <= 1'b1;
    end
    else
    begin
      case (state)
        ST_BUSY:
        begin
          if (busy_count == 12'h000)
          begin
            state <= ST_READY; // RULE22
            busy <= 1'b0;
          end
          else
          begin
            busy_count <= busy_count - 12'h001;
          end
        end
        ST_READY:
        begin
          busy <= 1'b0;
        end
        default:
        begin
          state <= ST_BUSY;
          busy <= 1'b1;
        end
      endcase
    end
  end

  // =========================================================================
  // control register writes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ref_ctrl <= RESET_REF_CTRL; // RULE22
      clock_div <= RESET_CLOCK_DIV; // RULE24
      filter_ctrl <= RESET_FILTER_CTRL;
      dac_ctrl <= RESET_DAC_CTRL;
      adc_ctrl <= RESET_ADC_CTRL;
      atten_reg <= RESET_DAC_ATTEN;
    end
    else if (take && word_write)
    begin
      // RULE23
      case (word_addr)
        ADDR_REF_CTRL: ref_ctrl <= word_data;
        ADDR_CLOCK_DIV: clock_div <= word_data; // RULE18
        ADDR_FILTER_CTRL: filter_ctrl <= word_data;
        ADDR_DAC_CTRL: dac_ctrl <= word_data;
        ADDR_ADC_CTRL: adc_ctrl <= word_data;
        ADDR_DAC_ATTEN: atten_reg <= word_data; // RULE10
        default: ref_ctrl <= ref_ctrl;
      endcase
    end
  end

  // =========================================================================
  // control register reads
  always_comb
  begin
    case (word_addr)
      ADDR_REF_CTRL: read_data = ref_ctrl;
      ADDR_CLOCK_DIV: read_data = clock_div;
      ADDR_FILTER_CTRL: read_data = filter_ctrl;
      ADDR_DAC_CTRL: read_data = dac_ctrl;
      ADDR_ADC_CTRL: read_data = adc_ctrl;
      ADDR_PEAK_LEVEL: read_data = {4'h0, peak_link.peak}; // RULE7 RULE6
      ADDR_DAC_ATTEN: read_data = atten_reg;
      default: read_data = 10'h000;
    endcase
  end

  // the data field of a read word is ignored
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      read_valid <= 1'b0;
      read_word <= 16'h0000;
    end
    else
    begin
      read_valid <= take && !word_write;
      if (take && !word_write)
      begin
        read_word <= {1'b0, word_addr, 1'b0, read_data}; // RULE23
      end
    end
  end

  // =========================================================================
  // peak capture
  assign peak_link.enable = adc_ctrl[PEAK_ENABLE_BIT]; // RULE5
  assign peak_link.level_valid = adc_valid;
  assign peak_link.level_code = adc_level_code;
  assign peak_link.clear = take && !word_write && (word_addr == ADDR_PEAK_LEVEL); // RULE8

  peak_capture u_peak (
    .ref_clk(ref_clk),
    .rst(rst),
    .link(peak_link.unit)
  );

  // =========================================================================
  // master clock divider chain
  // selection 3 is reserved and treated as pass-through
  always_comb
  begin
    for (int s = 0; s < 3; s++)
    begin
      ratio[s] = 3'h1;
    end
    if (clock_div[DIV1_LSB +: 2] == DIV_SEL_HALF) ratio[0] = 3'h2; // RULE16
    if (clock_div[DIV1_LSB +: 2] == DIV_SEL_ALT) ratio[0] = 3'h3;
    if (clock_div[DIV2_LSB +: 2] == DIV_SEL_HALF) ratio[1] = 3'h2;
    if (clock_div[DIV2_LSB +: 2] == DIV_SEL_ALT) ratio[1] = 3'h3;
    if (clock_div[DIV3_LSB +: 2] == DIV_SEL_HALF) ratio[2] = 3'h2; // RULE17
    if (clock_div[DIV3_LSB +: 2] == DIV_SEL_ALT) ratio[2] = 3'h4;
  end

  assign stage_tick[0] = 1'b1;

  // RULE15
  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_stage
      clock_prescaler u_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick_in(stage_tick[g]),
        .ratio(ratio[g]),
        .tick_out(stage_tick[g+1])
      );
    end
  endgenerate

  // =========================================================================
  // sample and modulator ticks
  // RULE14 RULE12 RULE3 RULE20 RULE19 RULE21
  always_comb
  begin
    if (low_delay)
    begin
      next_sample = int_master_clock_count[6:0] == 7'(CLKS_PER_SAMPLE_LOW_DELAY - 1);
    end
    else
    begin
      next_sample = int_master_clock_count == 8'(CLKS_PER_SAMPLE - 1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      int_master_clock_count <= 8'h00;
      int_master_tick <= 1'b0;
      sample_tick <= 1'b0;
      adc_mod_tick <= 1'b0;
      dac_mod_tick <= 1'b0;
    end
    else
    begin
      int_master_tick <= stage_tick[3];
      sample_tick <= stage_tick[3] && next_sample;
      if (stage_tick[3])
      begin
        int_master_clock_count <= next_sample ? 8'h00 : int_master_clock_count + 8'h01;
      end
      if (low_delay)
      begin
        // modulator keeps 64x the halved-period sample rate
        adc_mod_tick <= stage_tick[3] && int_master_clock_count[0];
        dac_mod_tick <= stage_tick[3];
      end
      else
      begin
        adc_mod_tick <= stage_tick[3] && (int_master_clock_count[1:0] == 2'h3);
        dac_mod_tick <= stage_tick[3] && int_master_clock_count[0];
      end
    end
  end

  // =========================================================================
  // channel controls
  // out-of-range gain codes clamp to the top step rather than wrap
  assign gain_step = (adc_ctrl[ADC_GAIN_LSB +: ADC_GAIN_W] > GAIN_STEP_MAX) ?
    GAIN_STEP_MAX : adc_ctrl[ADC_GAIN_LSB +: ADC_GAIN_W];

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      adc_gain_db <= 5'h00;
      adc_mute <= 1'b0;
      dac_mute <= 1'b0;
      dac_attenuation <= RESET_DAC_ATTEN;
      filter_bypass <= 1'b0;
      decim_delay_samples <= 6'(DECIM_DELAY_SAMPLES);
      ref_disable <= 1'b0;
    end
    else
    begin
      adc_gain_db <= 5'(gain_step * GAIN_STEP_DB); // RULE1
      adc_mute <= adc_ctrl[ADC_MUTE_BIT]; // RULE2
      dac_mute <= dac_ctrl[DAC_MUTE_BIT]; // RULE9
      dac_attenuation <= atten_reg; // RULE9
      filter_bypass <= low_delay; // RULE11
      decim_delay_samples <= low_delay ? 6'(LOW_DELAY_SAMPLES) : 6'(DECIM_DELAY_SAMPLES); // RULE4
      ref_disable <= ref_ctrl[REF_DISABLE_BIT]; // RULE13
    end
  end

  // =========================================================================
  // ADC output with mute
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      adc_out_valid <= 1'b0;
      adc_out <= '0;
    end
    else
    begin
      adc_out_valid <= adc_valid;
      if (adc_valid)
      begin
        adc_out <= adc_ctrl[ADC_MUTE_BIT] ? '0 : adc_sample; // RULE25
      end
    end
  end

endmodule

// file: logic/codec_ctl_pkg.sv
// Purpose: shared constants for the mono codec clock and channel control block
// Assumes: one clock (ref_clk) standing in for the external master clock
// Notes: control word is rw bit, register address, reserved bit, 10-bit data
package codec_ctl_pkg;

  // ==========================================================================
  // control word layout
  localparam int WORD_W = 16;
  localparam int DATA_W = 10;
  localparam int ADDR_W = 4;
  localparam int WORD_RW_BIT = 15;
  localparam int WORD_ADDR_LSB = 11;
  localparam int WORD_DATA_LSB = 0;

  // ==========================================================================
  // register addresses (A..G)
  localparam logic [3:0] ADDR_REF_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CLOCK_DIV = 4'h1;
  localparam logic [3:0] ADDR_FILTER_CTRL = 4'h2;
  localparam logic [3:0] ADDR_DAC_CTRL = 4'h3;
  localparam logic [3:0] ADDR_ADC_CTRL = 4'h4;
  localparam logic [3:0] ADDR_PEAK_LEVEL = 4'h5;
  localparam logic [3:0] ADDR_DAC_ATTEN = 4'h6;

  // ==========================================================================
  // field positions
  localparam int REF_DISABLE_BIT = 0;
  localparam int DIV1_LSB = 0;
  localparam int DIV2_LSB = 2;
  localparam int DIV3_LSB = 4;
  localparam int LOW_DELAY_BIT = 0;
  localparam int DAC_MUTE_BIT = 0;
  localparam int ADC_GAIN_LSB = 0;
  localparam int ADC_GAIN_W = 3;
  localparam int ADC_MUTE_BIT = 3;
  localparam int PEAK_ENABLE_BIT = 4;
  localparam int PEAK_W = 6;

  // ==========================================================================
  // reset values
  localparam logic [9:0] RESET_REF_CTRL = 10'h000;
  localparam logic [9:0] RESET_CLOCK_DIV = 10'h000;
  localparam logic [9:0] RESET_FILTER_CTRL = 10'h000;
  localparam logic [9:0] RESET_DAC_CTRL = 10'h000;
  localparam logic [9:0] RESET_ADC_CTRL = 10'h000;
  localparam logic [9:0] RESET_DAC_ATTEN = 10'h000;
  localparam logic [5:0] PEAK_FLOOR = 6'h3f;

  // ==========================================================================
  // divider selections and gain limit
  localparam logic [1:0] DIV_SEL_PASS = 2'h0;
  localparam logic [1:0] DIV_SEL_HALF = 2'h1;
  localparam logic [1:0] DIV_SEL_ALT = 2'h2;
  localparam logic [2:0] GAIN_STEP_MAX = 3'h4;
  localparam int GAIN_STEP_DB = 3;

  // ==========================================================================
  // timing
  localparam int RESET_CYCLES = 3072;
  localparam int CLKS_PER_SAMPLE = 256;
  localparam int CLKS_PER_SAMPLE_LOW_DELAY = 128;
  localparam int ADC_OVERSAMPLE = 64;
  localparam int DECIM_DELAY_US = 910;
  localparam int REF_RATE_KHZ = 48;
  localparam int DECIM_DELAY_SAMPLES = (DECIM_DELAY_US * REF_RATE_KHZ + 999) / 1000;
  localparam int LOW_DELAY_SAMPLES = 4;

endpackage

// file: logic/peak_capture.sv
`timescale 1ns/1ns
// Purpose: ADC peak level hold, cleared on read
// Assumes: smaller level code means louder signal
// Notes: a sample arriving with the clear starts the new capture
module peak_capture
  import codec_ctl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // core side
  peak_if.unit link
);

  logic enable_q;

  // =========================================================================
  // capture
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      link.peak <= PEAK_FLOOR;
      enable_q <= 1'b0;
    end
    else
    begin
      enable_q <= link.enable;
      if (!link.enable || (link.enable && !enable_q))
      begin
        link.peak <= PEAK_FLOOR;
      end
      else if (link.clear)
      begin
        // set wins over the clear: the sample seeds the new capture
        link.peak <= link.level_valid ? link.level_code : PEAK_FLOOR;
      end
      else if (link.level_valid && link.level_code < link.peak)
      begin
        link.peak <= link.level_code;
      end
    end
  end

endmodule

// file: logic/peak_if.sv
`timescale 1ns/1ns
// Purpose: carrier between the control core and the peak capture unit
// Assumes: all signals on ref_clk
// Notes: level_code is attenuation below full scale, 0 is loudest
interface peak_if;
  logic enable;
  logic level_valid;
  logic [5:0] level_code;
  logic clear;
  logic [5:0] peak;

  modport core (output enable, output level_valid, output level_code, output clear,
    input peak);
  modport unit (input enable, input level_valid, input level_code, input clear,
    output peak);
endinterface

// file: test/codec_control_asserts.sv
// Purpose: port-level checks for codec_control
// Assumes: one clock, rst synchronous active high
// Notes: bound from the bench top file
`timescale 1ns/1ns
module codec_control_asserts
  import codec_ctl_pkg::*;
#(
  parameter int SAMPLE_W = 24
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control port
  input wire logic ctl_valid,
  input wire logic [15:0] ctl_word,
  input wire logic read_valid,
  input wire logic [15:0] read_word,
  input wire logic busy,
  // adc path
  input wire logic adc_valid,
  input wire logic adc_out_valid,
  input wire logic [SAMPLE_W-1:0] adc_out,
  // ticks and controls
  input wire logic int_master_tick,
  input wire logic sample_tick,
  input wire logic [4:0] adc_gain_db,
  input wire logic adc_mute,
  input wire logic [9:0] dac_attenuation,
  input wire logic filter_bypass
);
  // ==========================================================================
  // helper counters
  logic [11:0] since_rst;
  logic [9:0] tick_cnt;
  logic [1:0] armed;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      since_rst <= 12'h000;
    else if (since_rst != 12'hfff)
      since_rst <= since_rst + 12'h001;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst || sample_tick)
      tick_cnt <= 10'h000;
    else
      tick_cnt <= tick_cnt + 10'(int_master_tick);
  end

  // a mode change leaves one odd period, so two ticks pass before checking
  always_ff @(posedge ref_clk)
  begin
    if (rst || $changed(filter_bypass))
      armed <= 2'h0;
    else if (sample_tick && armed != 2'h2)
      armed <= armed + 2'h1;
  end

  function automatic logic [4:0] gain_of(logic [2:0] s);
    return (s > GAIN_STEP_MAX) ? 5'h0c : 5'(s) * 5'h03;
  endfunction

  // ==========================================================================
  // sequences and assertions
  sequence s_read_taken;
    ctl_valid && !busy && !ctl_word[WORD_RW_BIT];
  endsequence

  sequence s_write_to(logic [3:0] a);
    ctl_valid && !busy && ctl_word[WORD_RW_BIT] && ctl_word[14:11] == a;
  endsequence

  AST_BUSY_IN_RESET: assert property (@(posedge ref_clk) rst |=> busy)
    else $error("busy low after a reset cycle");
  AST_BUSY_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    since_rst < 12'hbfe |-> busy) else $error("busy dropped too early");
  AST_BUSY_END: assert property (@(posedge ref_clk) disable iff (rst)
    since_rst > 12'hc01 |-> !busy) else $error("busy held too long");
  AST_READ_ANSWER: assert property (@(posedge ref_clk) disable iff (rst)
    s_read_taken |=> read_valid && read_word[15] == 1'b0 && read_word[10] == 1'b0
    && read_word[14:11] == $past(ctl_word[14:11])) else $error("bad read answer");
  AST_READ_CAUSE: assert property (@(posedge ref_clk) disable iff (rst)
    read_valid |-> $past(ctl_valid && !busy && !ctl_word[15]))
    else $error("read answer without a read");
  AST_ATTEN_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
    s_write_to(ADDR_DAC_ATTEN) |-> ##2 dac_attenuation == $past(ctl_word[9:0], 2))
    else $error("attenuation not updated");
  AST_GAIN_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
    s_write_to(ADDR_ADC_CTRL) |-> ##2 adc_gain_db == gain_of($past(ctl_word[2:0], 2)))
    else $error("gain not updated");
  AST_MUTE_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    adc_out_valid && adc_mute && $past(adc_mute) |-> adc_out == '0)
    else $error("muted sample not zero");
  AST_OUT_TIMING: assert property (@(posedge ref_clk) disable iff (rst)
    adc_out_valid == $past(adc_valid)) else $error("adc output timing");
  AST_SAMPLE_SPACING: assert property (@(posedge ref_clk) disable iff (rst)
    armed == 2'h2 && sample_tick |->
    tick_cnt + 10'(int_master_tick) == (filter_bypass ? 10'h080 : 10'h100))
    else $error("wrong internal ticks per sample");
endmodule

// file: test/host_model.sv
// Purpose: host processor issuing control words
// Assumes: words are already deserialised, one per ctl_valid pulse
// Notes: signals change on the falling edge of ref_clk
`timescale 1ns/1ns
module host_model
  import codec_ctl_pkg::*;
(
  // clock and device answers
  input wire logic ref_clk,
  input wire logic busy,
  input wire logic read_valid,
  input wire logic [15:0] read_word,
  // control words
  output logic ctl_valid,
  output logic [15:0] ctl_word
);
  initial
  begin
    ctl_valid = 1'b0;
    ctl_word = 16'h0000;
  end

  // released word lines show the inverse so stale data cannot pass
  task automatic send(input logic wr, input logic [3:0] a, input logic [9:0] d);
    @(negedge ref_clk);
    ctl_valid <= 1'b1;
    ctl_word <= {wr, a, 1'b0, d};
    @(negedge ref_clk);
    ctl_valid <= 1'b0;
    ctl_word <= ~{wr, a, 1'b0, d};
  endtask

  task automatic write_reg(input logic [3:0] a, input logic [9:0] d);
    send(1'b1, a, d);
  endtask

  task automatic read_reg(input logic [3:0] a, output logic [15:0] w);
    send(1'b0, a, 10'h3ff);
    if (read_valid !== 1'b1)
    begin
      @(posedge ref_clk);
      #1;
    end
    w = read_word;
  endtask

  task automatic wait_ready();
    for (int i = 0; i < 4000 && busy !== 1'b0; i++)
      @(negedge ref_clk);
  endtask
endmodule

// file: test/test_mono_codec_clock_and_channel_control.sv
// Purpose: self-checking bench for the codec control block
// Assumes: host_model sends control words, the bench drives the adc inputs
// Notes: inputs change on the falling edge of ref_clk
`timescale 1ns/1ns
module test_mono_codec_clock_and_channel_control;
  import codec_ctl_pkg::*;

  logic ref_clk, rst, ctl_valid, read_valid, busy, adc_valid, adc_out_valid;
  logic int_master_tick, sample_tick, adc_mod_tick, dac_mod_tick;
  logic adc_mute, dac_mute, filter_bypass, ref_disable;
  logic [15:0] ctl_word, read_word, w;
  logic [23:0] adc_sample, adc_out;
  logic [5:0] adc_level_code, decim_delay_samples;
  logic [4:0] adc_gain_db;
  logic [9:0] dac_attenuation;
  logic [9:0] div_sel [9] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h004, 10'h008,
    10'h010, 10'h020, 10'h006};
  int div_cnt [9] = '{96, 48, 32, 96, 48, 32, 48, 24, 16};
  int miscompares, n_checks, cycles;
  int cnt [4], base [4];

  codec_control #(.SAMPLE_W(24)) dut (.ref_clk, .rst, .ctl_valid, .ctl_word, .read_valid,
    .read_word, .busy, .adc_valid, .adc_sample, .adc_level_code, .adc_out_valid, .adc_out,
    .int_master_tick, .sample_tick, .adc_mod_tick, .dac_mod_tick, .adc_gain_db, .adc_mute,
    .dac_mute, .dac_attenuation, .filter_bypass, .decim_delay_samples, .ref_disable);
  host_model host (.ref_clk, .busy, .read_valid, .read_word, .ctl_valid, .ctl_word);

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // counting, checking and closing
  always @(posedge ref_clk)
  begin
    cnt[0] += int'(int_master_tick);
    cnt[1] += int'(sample_tick);
    cnt[2] += int'(adc_mod_tick);
    cnt[3] += int'(dac_mod_tick);
    cycles++;
    if (cycles == 20000)
    begin
      $display("[ERR] %0t run too long", $time);
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_count(input int got, input int exp);
    n_checks++;
    if (got != exp)
    begin
      miscompares++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [9:0] d);
    host.read_reg(a, w);
    chk_word(32'(w), 32'({1'b0, a, 1'b0, d}));
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // counts land in base as ticks seen over exactly n rising edges
  task automatic span(input int n);
    base = cnt;
    tick(n);
    foreach (base[i])
      base[i] = cnt[i] - base[i];
  endtask

  task automatic feed(input logic [5:0] lvl, input logic [23:0] d);
    @(negedge ref_clk);
    adc_valid = 1'b1;
    adc_sample = d;
    adc_level_code = lvl;
    @(negedge ref_clk);
    adc_valid = 1'b0;
    adc_sample = ~d;
    adc_level_code = ~lvl;
  endtask

  // ==========================================================================
  // tests
  initial
  begin
    rst = 1'b1;
    adc_valid = 1'b0;
    adc_sample = 24'h000000;
    adc_level_code = 6'h00;
    tick(10);
    rst = 1'b0;
    host.wait_ready();
    for (int a = 0; a < 16; a++)
      rd(4'(a), (a == 5) ? 10'h03f : 10'h000);
    span(256);
    chk_count(base[0], 256);
    chk_count(base[1], 1);
    $display("test reset done");
    for (int a = 0; a < 8; a++)
      host.write_reg(4'(a), 10'h3c5 + 10'(a));
    tick(2);
    for (int a = 0; a < 8; a++)
      rd(4'(a), (a == 5) ? 10'h03f : (a == 7) ? 10'h000 : 10'h3c5 + 10'(a));
    chk_word(32'({ref_disable, filter_bypass, dac_mute, adc_mute}), 32'hd);
    chk_word(32'({adc_gain_db, dac_attenuation, decim_delay_samples}), 32'h3f2c4);
    host.write_reg(ADDR_DAC_CTRL, 10'h001);
    host.write_reg(ADDR_DAC_ATTEN, 10'h3ff);
    tick(2);
    chk_word(32'({dac_mute, dac_attenuation}), 32'h7ff);
    host.write_reg(ADDR_DAC_CTRL, 10'h000);
    tick(2);
    chk_word(32'({dac_mute, dac_attenuation}), 32'h3ff);
    $display("test registers done");
    for (int s = 0; s < 8; s++)
    begin
      host.write_reg(ADDR_ADC_CTRL, 10'(s));
      tick(2);
      chk_word(32'(adc_gain_db), (s > 4) ? 32'hc : 32'(s * 3));
    end
    host.write_reg(ADDR_ADC_CTRL, 10'h008);
    tick(2);
    feed(6'h05, 24'h5a5a5a);
    chk_word(32'({adc_out_valid, adc_out}), 32'h1000000);
    host.write_reg(ADDR_ADC_CTRL, 10'h000);
    tick(2);
    feed(6'h05, 24'h123456);
    chk_word(32'({adc_out_valid, adc_out}), 32'h1123456);
    rd(ADDR_PEAK_LEVEL, 10'h03f);
    host.write_reg(ADDR_ADC_CTRL, 10'h010);
    tick(3);
    feed(6'h14, 24'h000100);
    feed(6'h07, 24'h000200);
    feed(6'h1e, 24'h000300);
    rd(ADDR_PEAK_LEVEL, 10'h007);
    rd(ADDR_PEAK_LEVEL, 10'h03f);
    feed(6'h00, 24'h7fffff);
    rd(ADDR_PEAK_LEVEL, 10'h000);
    $display("test adc done");
    for (int i = 0; i < 9; i++)
    begin
      host.write_reg(ADDR_CLOCK_DIV, div_sel[i]);
      tick(40);
      span(96);
      chk_count(base[0], div_cnt[i]);
    end
    host.write_reg(ADDR_CLOCK_DIV, 10'h000);
    $display("test dividers done");
    for (int m = 1; m >= 0; m--)
    begin
      host.write_reg(ADDR_FILTER_CTRL, 10'(m));
      tick(600);
      span(1024);
      chk_count(base[1], 4 << m);
      chk_count(base[2], 256 << m);
      chk_count(base[3], 512 << m);
      chk_word(32'(decim_delay_samples), m ? 32'h4 : 32'h2c);
    end
    $display("test rates done");
    host.write_reg(ADDR_DAC_ATTEN, 10'h155);
    @(negedge ref_clk);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    host.write_reg(ADDR_DAC_ATTEN, 10'h2aa);
    chk_word(32'({busy, dac_attenuation}), 32'h400);
    host.wait_ready();
    rd(ADDR_DAC_ATTEN, 10'h000);
    $display("test second reset done");
    give_verdict();
  end
endmodule

bind codec_control codec_control_asserts #(.SAMPLE_W(SAMPLE_W)) chk (.ref_clk, .rst,
  .ctl_valid, .ctl_word, .read_valid, .read_word, .busy, .adc_valid, .adc_out_valid, .adc_out,
  .int_master_tick, .sample_tick, .adc_gain_db, .adc_mute, .dac_attenuation, .filter_bypass);
